// File: shared/vjl_pkg.sv
// constants shared by the emergency vme-to-test-port loader and its helpers
// assumes a 10 MHz pclk and an apb master that owns the small control map
package vjl_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int TCK_SETUP_NS = 100; // least time from tms/tdi change to tck rise
    localparam int TCK_HIGH_NS = 50;   // least tck high time
    localparam int TCK_SETUP_CYC = (TCK_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TCK_HIGH_CYC = (TCK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // vme decode
    // ****************************************
    localparam logic [5:0] AM_USER_0 = 6'h19;
    localparam logic [5:0] AM_USER_1 = 6'h1a;
    localparam logic [5:0] AM_USER_2 = 6'h1d;
    localparam logic [5:0] AM_USER_3 = 6'h1e;
    localparam logic [16:0] LOADER_OFFSET = 17'h03fff; // a[18:2]
    localparam int ADDR_OFS_HI = 18;
    localparam int ADDR_OFS_LO = 2;
    localparam int ADDR_BASE_HI = 23;
    localparam int ADDR_BASE_LO = 19;
    localparam int DATA_TMS = 0;
    localparam int DATA_TDI = 1;

    // ****************************************
    // mode switch, numbered 8..1
    // ****************************************
    localparam int SW_CLK_SEL = 8;
    localparam int SW_BASE_SEL = 7;
    localparam int SW_REV_SEL = 6;
    localparam int SW_BASE_HI = 5;
    localparam int SW_BASE_LO = 1;

    // ****************************************
    // pin synchroniser bundle
    // ****************************************
    localparam int SYNC_W = 19;
    localparam int SY_AS = 0;
    localparam int SY_DS0 = 1;
    localparam int SY_DS1 = 2;
    localparam int SY_WRITE = 3;
    localparam int SY_LWORD = 4;
    localparam int SY_SW_LO = 5;   // switch bits 8..1 at 12..5
    localparam int SY_GA_LO = 13;  // ga_n at 17..13
    localparam int SY_FALLBACK = 18;
    localparam logic [18:0] SYNC_RST = 19'h3e01f; // strobes and ga_n idle high

    // ****************************************
    // apb map
    // ****************************************
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_WRCOUNT = 12'h008;
    localparam int CTRL_CLK_OVR_EN = 0;
    localparam int CTRL_CLK_OVR_SEL = 1;
    localparam int CTRL_ENGINE_SEL = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;

    typedef enum logic [1:0] {
        VJL_IDLE = 2'b01,
        VJL_ACK = 2'b10
    } vjl_state_t;
endpackage : vjl_pkg

// File: logic/vjl_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes inputs come from outside the pclk domain
`timescale 1ns/1ps
`default_nettype none
module vjl_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pins in, filtered levels out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } vjl_sync_t;

    vjl_sync_t r, nxt;

    // first stage feeds only the second; a change counts once stages two and three agree
    always_comb begin
        nxt = r;
        nxt.s1 = din;
        nxt.s2 = r.s1;
        nxt.s3 = r.s2;
        for (int i = 0; i < W; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                nxt.q[i] = r.s3[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= {RST, RST, RST, RST};
        end else begin
            r <= nxt;
        end
    end

    assign dout = r.q;
endmodule : vjl_sync
`default_nettype wire

// File: logic/vjl_tck_gen.sv
// single test-clock pulse generator: setup delay, then one high phase
// assumes start is a one-cycle pulse, only given while busy is low
`timescale 1ns/1ps
`default_nettype none
module vjl_tck_gen #(
    parameter int SETUP_CYC = 1,
    parameter int HIGH_CYC = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic start,
    output logic busy,
    // test clock
    output logic tck
);
    typedef struct packed {
        logic [7:0] cnt;
        logic setup;
        logic high;
    } vjl_tck_t;

    vjl_tck_t r, nxt;

    // tms/tdi settle for the setup time before the rising edge
    always_comb begin
        nxt = r;
        if (start && !r.setup && !r.high) begin
            nxt.setup = 1'b1;
            nxt.cnt = 8'(SETUP_CYC - 1);
        end else if (r.cnt != 8'h00) begin
            nxt.cnt = r.cnt - 8'h01;
        end else if (r.setup) begin
            nxt.setup = 1'b0;
            nxt.high = 1'b1;
            nxt.cnt = 8'(HIGH_CYC - 1);
        end else begin
            nxt.high = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign busy = r.setup | r.high;
    assign tck = r.high;
endmodule : vjl_tck_gen
`default_nettype wire

// File: logic/vjl_loader.sv
// emergency vme-to-test-port loader with mode switch decode and apb control
// assumes vme address, modifier and data are stable while the strobes are low,
// and that the configuration prom/fpga chain hangs on the tck/tms/tdi outputs
//
// Function
// - only writes carrying modifier 0x19, 0x1a, 0x1d or 0x1e are answered; all others are ignored.
// - address bits 31..24 are ignored and bits 18..2 must equal 0x3fff.
// - address bits 23..19 must match the geographic slot address, or zero where the crate has none.
// - an accepted write drives tdi from data bit 1 and tms from data bit 0.
// - the loader needs nothing from the fpga and works while it is blank or broken.
// - cycles are taken as 24-bit address, 32-bit data writes.
// - switch bit 7 low takes the base from the geographic address, high from switch bits 5..1.
// - switch bit 8 high picks the oscillator, low the front panel clock, software may override.
// - switch bit 6 picks firmware revision 1 when high, and the fallback line forces revision 0.
// - the a24 base from geographic address or switch is shared with the standard register decode.
// - the board is a slave for a24/d32 and a32/d64 accesses.
// - a faster fpga test-port engine may take over the chain once the fpga runs.
// - the other 30 data bits are ignored and the oscillator clocks prom configuration.
`timescale 1ns/1ps
`default_nettype none
module vjl_loader #(
    parameter int ADDR_W = 12,
    parameter int CNT_W = 16
) (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // vme slave pins
    input wire logic vme_as_n,
    input wire logic vme_ds0_n,
    input wire logic vme_ds1_n,
    input wire logic vme_write_n,
    input wire logic vme_lword_n,
    input wire logic [5:0] vme_am,
    input wire logic [31:1] vme_addr,
    input wire logic [31:0] vme_data,
    input wire logic [4:0] vme_ga_n,
    input wire logic vme_dtack_n_i,
    output logic vme_dtack_n_o,
    output logic vme_dtack_oe_n,
    // board mode switch and fallback boot line
    input wire logic [8:1] mode_switch,
    input wire logic fallback_revision_select,
    // fpga test-port engine
    input wire logic fpga_tck,
    input wire logic fpga_tms,
    input wire logic fpga_tdi,
    // test port chain
    output logic jtag_tck,
    output logic jtag_tms,
    output logic jtag_tdi,
    // board decode
    output logic [4:0] a24_base,
    output logic clk_src_osc,
    output logic fw_rev_sel
);
    import vjl_pkg::*;

    // ****************************************
    // helpers
    // ****************************************

    function automatic logic am_is_loader(input logic [5:0] am);
        am_is_loader = (am == AM_USER_0) || (am == AM_USER_1) || (am == AM_USER_2) || (am == AM_USER_3);
    endfunction : am_is_loader

    function automatic logic addr_is_loader(input logic [31:1] a, input logic [4:0] base);
        // a[31:24] take no part in the match
        addr_is_loader = (a[ADDR_OFS_HI:ADDR_OFS_LO] == LOADER_OFFSET)
                      && (a[ADDR_BASE_HI:ADDR_BASE_LO] == base);
    endfunction : addr_is_loader

    typedef struct packed {
        vjl_state_t st;
        logic tms;
        logic tdi;
        logic [2:0] ctrl;
        logic [CNT_W-1:0] wr_cnt;
        logic [31:0] rdata;
    } vjl_loader_t;

    vjl_loader_t r, nxt;

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins;
    logic [8:1] sw;
    logic [4:0] ga;
    logic ds_low;
    logic ds_high;
    logic accept;
    logic tck_busy;
    logic loader_tck;
    logic apb_setup;
    logic apb_access;
    logic apb_mapped;

    // ****************************************
    // pin synchronisers
    // ****************************************

    // strobes, switches and slot pins are asynchronous to pclk; the bus lines ride behind the strobes
    assign pins_raw = {fallback_revision_select, vme_ga_n, mode_switch,
                       vme_lword_n, vme_write_n, vme_ds1_n, vme_ds0_n, vme_as_n};

    vjl_sync #(
        .W(SYNC_W),
        .RST(SYNC_RST)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(pins_raw),
        .dout(pins)
    );

    assign sw = pins[SY_SW_LO+7:SY_SW_LO];
    assign ga = ~pins[SY_GA_LO+4:SY_GA_LO]; // slot pins are active low

    // ****************************************
    // mode switch decode
    // ****************************************

    // the same base serves this loader and the standard a24 decode in the fpga
    assign a24_base = sw[SW_BASE_SEL] ? sw[SW_BASE_HI:SW_BASE_LO] : ga;

    // software override exists because the front panel clock may be absent at power-up
    assign clk_src_osc = r.ctrl[CTRL_CLK_OVR_EN] ? r.ctrl[CTRL_CLK_OVR_SEL] : sw[SW_CLK_SEL];

    // fallback line only matters when revision 1 was chosen
    assign fw_rev_sel = sw[SW_REV_SEL] & ~pins[SY_FALLBACK];

    // ****************************************
    // vme write decode
    // ****************************************

    // both data strobes plus long word mark a d32 transfer; reads are never answered
    assign ds_low = !pins[SY_DS0] && !pins[SY_DS1];
    assign ds_high = pins[SY_DS0] && pins[SY_DS1];
    assign accept = (r.st == VJL_IDLE) && !pins[SY_AS] && ds_low
                 && !pins[SY_LWORD] && !pins[SY_WRITE]
                 && am_is_loader(vme_am)
                 && addr_is_loader(vme_addr, a24_base)
                 && !tck_busy; // holding dtack until the pulse is free keeps one pulse per write

    // ****************************************
    // test clock pulse
    // ****************************************

    vjl_tck_gen #(
        .SETUP_CYC(TCK_SETUP_CYC),
        .HIGH_CYC(TCK_HIGH_CYC)
    ) u_tck (
        .pclk(pclk),
        .presetn(presetn),
        .start(accept),
        .busy(tck_busy),
        .tck(loader_tck)
    );

    // the emergency path is the default so a blank fpga never blocks the chain
    assign jtag_tck = r.ctrl[CTRL_ENGINE_SEL] ? fpga_tck : loader_tck;
    assign jtag_tms = r.ctrl[CTRL_ENGINE_SEL] ? fpga_tms : r.tms;
    assign jtag_tdi = r.ctrl[CTRL_ENGINE_SEL] ? fpga_tdi : r.tdi;

    // open-drain acknowledge: drive low only while a write is held
    assign vme_dtack_n_o = 1'b0;
    assign vme_dtack_oe_n = (r.st != VJL_ACK);

    // ****************************************
    // apb slave
    // ****************************************

    // zero wait states; read data is caught at the setup edge so it comes from a flop
    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable;
    assign apb_mapped = (paddr == REG_CTRL) || (paddr == REG_STATUS) || (paddr == REG_WRCOUNT);
    assign pready = 1'b1;
    assign pslverr = apb_access && !apb_mapped;
    assign prdata = r.rdata;

    // ****************************************
    // state update
    // ****************************************

    always_comb begin
        nxt = r;
        unique case (r.st)
            VJL_IDLE: begin
                if (accept) begin
                    // only the two low data bits reach the chain
                    nxt.tms = vme_data[DATA_TMS];
                    nxt.tdi = vme_data[DATA_TDI];
                    nxt.wr_cnt = r.wr_cnt + CNT_W'(1);
                    nxt.st = VJL_ACK;
                end
            end
            VJL_ACK: begin
                // release when the master lifts both data strobes
                if (ds_high) begin
                    nxt.st = VJL_IDLE;
                end
            end
            default: begin
                nxt.st = VJL_IDLE;
            end
        endcase
        if (apb_setup) begin
            nxt.rdata = 32'h0000_0000;
            if (paddr == REG_CTRL) begin
                nxt.rdata[2:0] = r.ctrl;
            end else if (paddr == REG_STATUS) begin
                nxt.rdata = {21'h000000, fw_rev_sel, clk_src_osc, a24_base,
                             tck_busy, (r.st == VJL_ACK), r.tdi, r.tms};
            end else if (paddr == REG_WRCOUNT) begin
                nxt.rdata[CNT_W-1:0] = r.wr_cnt;
            end
        end
        if (apb_access && pwrite && (paddr == REG_CTRL)) begin
            nxt.ctrl = pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.st <= VJL_IDLE;
            r.tms <= 1'b0;
            r.tdi <= 1'b0;
            r.ctrl <= CTRL_RST;
            r.wr_cnt <= '0;
            r.rdata <= 32'h0000_0000;
        end else begin
            r <= nxt;
        end
    end

    // ****************************************
    // checks
    // ****************************************

    property p_am_filter;
        @(posedge pclk) disable iff (!presetn)
        (r.st == VJL_IDLE) && !am_is_loader(vme_am) |=> vme_dtack_oe_n;
    endproperty
    a_am_filter: assert property (p_am_filter) else $error("dtack after foreign modifier");

    property p_offset;
        @(posedge pclk) disable iff (!presetn)
        $fell(vme_dtack_oe_n) |-> $past(vme_addr[ADDR_OFS_HI:ADDR_OFS_LO]) == LOADER_OFFSET;
    endproperty
    a_offset: assert property (p_offset) else $error("dtack on wrong offset");

    property p_base;
        @(posedge pclk) disable iff (!presetn)
        $fell(vme_dtack_oe_n) |-> $past(vme_addr[ADDR_BASE_HI:ADDR_BASE_LO]) == $past(a24_base);
    endproperty
    a_base: assert property (p_base) else $error("dtack on wrong slot base");

    property p_lines;
        @(posedge pclk) disable iff (!presetn)
        accept |=> (r.tms == $past(vme_data[DATA_TMS])) && (r.tdi == $past(vme_data[DATA_TDI]));
    endproperty
    a_lines: assert property (p_lines) else $error("tms/tdi not taken from data");

    property p_d32_write;
        @(posedge pclk) disable iff (!presetn)
        $fell(vme_dtack_oe_n) |-> !$past(pins[SY_WRITE]) && !$past(pins[SY_LWORD]);
    endproperty
    a_d32_write: assert property (p_d32_write) else $error("dtack on non d32 write");

    property p_one_pulse;
        @(posedge pclk) disable iff (!presetn)
        accept && !r.ctrl[CTRL_ENGINE_SEL] |=> !loader_tck ##1 loader_tck ##1 !loader_tck;
    endproperty
    a_one_pulse: assert property (p_one_pulse) else $error("tck pulse shape wrong");

    property p_fallback;
        @(posedge pclk) disable iff (!presetn)
        pins[SY_FALLBACK] |-> !fw_rev_sel;
    endproperty
    a_fallback: assert property (p_fallback) else $error("fallback did not force revision 0");

    property p_clk_ovr;
        @(posedge pclk) disable iff (!presetn)
        apb_access && pwrite && (paddr == REG_CTRL) && pwdata[CTRL_CLK_OVR_EN]
            |=> clk_src_osc == $past(pwdata[CTRL_CLK_OVR_SEL]);
    endproperty
    a_clk_ovr: assert property (p_clk_ovr) else $error("clock override not applied");

    property p_base_sel;
        @(posedge pclk) disable iff (!presetn)
        sw[SW_BASE_SEL] |-> a24_base == sw[SW_BASE_HI:SW_BASE_LO];
    endproperty
    a_base_sel: assert property (p_base_sel) else $error("switch base not used");

    property p_release;
        @(posedge pclk) disable iff (!presetn)
        (r.st == VJL_ACK) && ds_high |=> vme_dtack_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("dtack held after strobes rose");
endmodule : vjl_loader
`default_nettype wire

// File: tb/vjl_vme_master.sv
// vme bus master model: issues a24 cycles and waits on the pulled-up acknowledge wire
// assumes pclk as its timing base; dtack_n reads high whenever nobody pulls it
`timescale 1ns/1ps
`default_nettype none
module vjl_vme_master (
    // timing
    input wire logic pclk,
    // bus lines driven by the master
    output logic as_n,
    output logic ds0_n,
    output logic ds1_n,
    output logic write_n,
    output logic lword_n,
    output logic [5:0] am,
    output logic [31:1] addr,
    output logic [31:0] data,
    // acknowledge wire
    input wire logic dtack_n
);
    // idle bus: strobes high, lines holding a pattern no decode accepts
    initial begin
        as_n = 1'b1;
        ds0_n = 1'b1;
        ds1_n = 1'b1;
        write_n = 1'b1;
        lword_n = 1'b1;
        am = 6'h3f;
        addr = '1;
        data = '1;
    end

    // one cycle; ack tells whether the slave answered within 20 clocks
    task automatic cycle(input logic [5:0] a, input logic [31:0] ad, input logic [31:0] d,
                         input logic wr, input logic lw, output logic ack);
        int n;
        @(posedge pclk);
        am <= a;
        addr <= ad[31:1];
        data <= d;
        write_n <= ~wr;
        lword_n <= ~lw;
        @(posedge pclk);
        as_n <= 1'b0;
        @(posedge pclk);
        ds0_n <= 1'b0;
        ds1_n <= 1'b0;
        ack = 1'b0;
        for (n = 0; n < 20 && ack == 1'b0; n++) begin
            @(posedge pclk);
            ack = (dtack_n === 1'b0);
        end
        as_n <= 1'b1;
        ds0_n <= 1'b1;
        ds1_n <= 1'b1;
        for (n = 0; n < 20 && dtack_n !== 1'b1; n++) begin
            @(posedge pclk);
        end
        // the slave samples strobes late, so hold lines a little before letting go
        repeat (4) @(posedge pclk);
        am <= ~a;
        addr <= ~ad[31:1];
        data <= ~d;
    endtask : cycle
endmodule : vjl_vme_master
`default_nettype wire

// File: tb/test_vme_jtag_emergency_loader.sv
// self-checking bench for the emergency loader: apb tasks, vme master model, test-port watch
// assumes zero-wait apb answers and vme acknowledges within 20 clocks of the strobes
`timescale 1ns/1ps
`default_nettype none
module test_vme_jtag_emergency_loader;
    import vjl_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, as_n, ds0_n, ds1_n, write_n, lword_n, dtack_o, dtack_oe_n, dtack_w;
    logic [5:0] am;
    logic [31:1] vaddr;
    logic [31:0] vdata;
    logic [4:0] ga_n = 5'h1f, base;
    logic [8:1] mode_sw = 8'h00;
    logic fallback = 1'b0, f_tck = 1'b0, f_tms = 1'b0, f_tdi = 1'b0;
    logic tck, tms, tdi, clk_osc, rev, tms_rise, tdi_rise;
    logic [5:0] ams [4] = '{6'h19, 6'h1a, 6'h1d, 6'h1e};
    int seq [14] = '{1, 1, 0, 0, 0, 2, 0, 2, 2, 0, 2, 1, 1, 0};
    int num_errors = 0, cmp_count = 0, tck_cnt = 0, acc_cnt = 0;

    // open-drain acknowledge with pull-up
    assign dtack_w = dtack_oe_n ? 1'b1 : dtack_o;

    vjl_loader u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .vme_as_n(as_n), .vme_ds0_n(ds0_n), .vme_ds1_n(ds1_n), .vme_write_n(write_n),
        .vme_lword_n(lword_n), .vme_am(am), .vme_addr(vaddr), .vme_data(vdata), .vme_ga_n(ga_n),
        .vme_dtack_n_i(dtack_w), .vme_dtack_n_o(dtack_o), .vme_dtack_oe_n(dtack_oe_n),
        .mode_switch(mode_sw), .fallback_revision_select(fallback), .fpga_tck(f_tck),
        .fpga_tms(f_tms), .fpga_tdi(f_tdi), .jtag_tck(tck), .jtag_tms(tms), .jtag_tdi(tdi),
        .a24_base(base), .clk_src_osc(clk_osc), .fw_rev_sel(rev));

    vjl_vme_master u_vme (.pclk(pclk), .as_n(as_n), .ds0_n(ds0_n), .ds1_n(ds1_n), .write_n(write_n),
        .lword_n(lword_n), .am(am), .addr(vaddr), .data(vdata), .dtack_n(dtack_w));

    // 10 MHz clock
    initial begin
        forever #50 pclk = ~pclk;
    end

    // count test-clock pulses and catch the levels the chain samples
    always @(posedge tck) begin
        tck_cnt++;
        tms_rise = tms;
        tdi_rise = tdi;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic msw(input logic [8:1] sw, input logic [4:0] g, input logic fb, input logic [6:0] exp);
        mode_sw <= sw;
        ga_n <= g;
        fallback <= fb;
        repeat (6) @(posedge pclk);
        #1;
        chk("base osc rev", exp, {base, clk_osc, rev});
    endtask : msw

    // a refused cycle must leave levels, pulse count and acknowledge untouched
    task automatic vw(input logic [5:0] a, input logic [31:0] ad, input logic [31:0] d,
                      input logic wr, input logic lw, input logic ok);
        int c0;
        logic ack;
        logic [1:0] lv;
        c0 = tck_cnt;
        lv = {tdi, tms};
        u_vme.cycle(a, ad, d, wr, lw, ack);
        if (ok) begin
            acc_cnt++;
            lv = d[1:0];
        end
        chk("dtack", 32'(ok), 32'(ack));
        chk("tck pulses", 32'(ok), tck_cnt - c0);
        chk("tdi tms", 32'(lv), 32'({tdi, tms}));
        if (ok) chk("tdi tms at tck rise", 32'(lv), 32'({tdi_rise, tms_rise}));
    endtask : vw

    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        chk("reset outputs", 32'h8, {dtack_oe_n, tck, tms, tdi});
        // clock source is set before anything else
        apb(1'b1, REG_CTRL, 32'h3);
        apb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl readback", 32'h3, rd);
        // expected value is {base, oscillator, revision}
        msw(8'hd6, 5'h1a, 1'b0, {5'h16, 1'b1, 1'b0});
        msw(8'h26, 5'h1a, 1'b0, {5'h05, 1'b1, 1'b1});
        msw(8'h26, 5'h1a, 1'b1, {5'h05, 1'b1, 1'b0});
        apb(1'b1, REG_CTRL, 32'h1);
        msw(8'h06, 5'h1a, 1'b0, {5'h05, 1'b0, 1'b0});
        // every user modifier, junk in a[31:24] and in the unused data bits; fpga left idle
        for (int i = 0; i < 4; i++) vw(ams[i], 32'ha528fffc, 32'hdeadbee0 | 32'(i), 1, 1, 1);
        // instruction shift walk, one step per write
        for (int k = 0; k < 14; k++) vw(ams[k % 4], 32'h0028fffc, 32'(seq[k]), 1, 1, 1);
        vw(6'h39, 32'h0028fffc, 32'h3, 1, 1, 0);
        vw(6'h1b, 32'h0028fffc, 32'h3, 1, 1, 0);
        vw(6'h19, 32'h0028fff8, 32'h3, 1, 1, 0);
        vw(6'h19, 32'h0030fffc, 32'h3, 1, 1, 0);
        vw(6'h1a, 32'h0028fffc, 32'h3, 0, 1, 0);
        vw(6'h1d, 32'h0028fffc, 32'h3, 1, 0, 0);
        // crate without slot pins: base is zero
        msw(8'h00, 5'h1f, 1'b0, 7'h00);
        vw(6'h19, 32'h0028fffc, 32'h3, 1, 1, 0);
        vw(6'h1e, 32'hff00fffc, 32'h2, 1, 1, 1);
        apb(1'b0, REG_WRCOUNT, 32'h0);
        chk("write count", 32'(acc_cnt[15:0]), rd);
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped read", 32'h1, {rd[30:0], err});
        // chain handed to the fpga engine, then back
        apb(1'b1, REG_CTRL, 32'h4);
        f_tms <= 1'b1;
        f_tck <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
        chk("fpga engine levels", 32'h5, {tck, tdi, tms});
        apb(1'b1, REG_CTRL, 32'h0);
        f_tck <= 1'b0;
        repeat (3) @(posedge pclk);
        #1;
        chk("loader levels back", 32'h2, {tck, tdi, tms});
        // override off: the clock source follows switch bit 8 alone
        @(posedge pclk);
        msw(8'h80, 5'h1f, 1'b0, {5'h00, 1'b1, 1'b0});
        // status: osc at bit 9, last write left tdi high and tms low
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status", 32'h0000_0202, rd);
        report_and_stop();
    end

    // cut a hang short
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        report_and_stop();
    end
endmodule : test_vme_jtag_emergency_loader
`default_nettype wire
